// ---- lcdc_pkg.sv ----
// Purpose: shared constants for the strobe host bus port
// Assumes: pclk at 125 MHz drives both ends
// Notes: straps and windows follow the strobe bus family
package lcdc_pkg;
	// Clock and link timing
	localparam int PCLK_PERIOD_NS = 8;
	localparam int HBCLK_PERIOD_NS = 125;
	localparam int HBCLK_HALF = (HBCLK_PERIOD_NS / PCLK_PERIOD_NS) / 2;
	// Pixel source clock limits in MHz, with and without divide-by-two
	localparam int PIXCLK_MAX_MHZ = 25;
	localparam int PIXCLK_DIV2_MAX_MHZ = 50;
	// Strap decode
	localparam logic [2:0] CFG_STROBE_FAMILY = 3'h7;
	// Address windows
	localparam logic [15:0] MEM_FIRST = 16'h0000;
	localparam logic [15:0] MEM_LAST = 16'h9fff;
	localparam logic [15:0] REG_FIRST = 16'hffe0;
	localparam logic [15:0] GAP_READ_VALUE = 16'h0000;
	// Host end pacing in pclk cycles
	localparam logic [3:0] HOST_SETTLE = 4'h6;
	localparam logic [3:0] HOST_RECOVER = 4'h4;
	// Host APB register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_WDATA = 8'h04;
	localparam logic [7:0] OFS_RDATA = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_STRAP = 8'h10;
	// CTRL fields
	localparam int CTRL_WRITE_BIT = 16;
	localparam int CTRL_HIGH_BIT = 17;
	// STRAP fields and reset value
	localparam int STRAP_ENDIAN_BIT = 0;
	localparam int STRAP_BS_BIT = 1;
	localparam logic [1:0] STRAP_RESET = 2'h2;
endpackage : lcdc_pkg

// ---- lcdc_link_if.sv ----
// Purpose: pins between host glue and the controller port
// Assumes: data lines resolved here from both enables
// Notes: undriven data lines read as pulled high
`timescale 1ns/1ps
interface lcdc_link_if;
	logic host_bus_clock; // Link clock from host end
	logic [2:0] bus_config_straps; // Bus family straps
	logic endian_strap; // High selects big endian
	logic bus_status_n; // Strap for strobe mode
	logic rd_wr_n; // Unused direction pin, tied high
	logic chip_select_n; // Decoded chip select
	logic read_strobe_n; // Read strobe
	logic low_write_strobe_n; // Write strobe
	logic high_byte_enable_n; // High byte enable
	logic [15:0] host_address_inputs; // Address
	logic [15:0] host_data_out; // Host drive value
	logic host_data_oe; // Host drives data
	logic [15:0] dev_data_out; // Device drive value
	logic dev_data_oe; // Device drives data
	logic wait_n; // Device wait, low holds host
	logic [15:0] host_data_lines; // Resolved bus level
	assign host_data_lines = host_data_oe ? host_data_out : (dev_data_oe ? dev_data_out : 16'hffff);
	modport dev (
		input host_bus_clock, bus_config_straps, endian_strap, bus_status_n, rd_wr_n,
		input chip_select_n, read_strobe_n, low_write_strobe_n, high_byte_enable_n,
		input host_address_inputs, host_data_lines,
		output dev_data_out, dev_data_oe, wait_n
	);
	modport host (
		output host_bus_clock, bus_config_straps, endian_strap, bus_status_n, rd_wr_n,
		output chip_select_n, read_strobe_n, low_write_strobe_n, high_byte_enable_n,
		output host_address_inputs, host_data_out, host_data_oe,
		input host_data_lines, wait_n
	);
endinterface : lcdc_link_if

// ---- lcdc_host_end.sv ----
// Purpose: host glue that runs strobe cycles ordered over APB
// Assumes: device end on the same link interface
// Notes: one transfer at a time; writes to CTRL while busy are ignored
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
module lcdc_host_end
	import lcdc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link pins
	lcdc_link_if.host lnk
);
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_SETUP = 5'b00010,
		H_SETTLE = 5'b00100,
		H_WAIT = 5'b01000,
		H_RECOV = 5'b10000
	} lcdc_hstate_t;

	lcdc_hstate_t state_reg; // Transfer sequencer
	logic [17:0] ctrl_reg; // Address, direction, high lane
	logic [15:0] wdata_reg; // Write data
	logic [15:0] rdata_reg; // Captured read data
	logic done_reg; // Sticky transfer done
	logic [1:0] strap_reg; // Board straps under software control
	logic [3:0] cnt_reg; // Settle and recovery count
	logic [3:0] div_reg; // Link clock divider
	logic hbclk_reg; // Link clock out
	logic wait_s1_reg; // Wait synchroniser, first stage
	logic wait_s2_reg; // Wait synchroniser, second stage
	logic cs_reg, rd_reg, we0_reg, we1_reg, doe_reg; // Pin drivers
	logic [15:0] addr_reg; // Address pins
	logic apb_wr; // Write taken this cycle
	logic go; // Start request

	// Writes land only at the edge where the master sees pready high
	assign apb_wr = psel & penable & pwrite & pready;
	assign go = apb_wr & (paddr == OFS_CTRL) & state_reg[0];

	// Pins come straight from flops, except the fixed bus family straps and direction pin
	assign lnk.host_bus_clock = hbclk_reg;
	assign lnk.bus_config_straps = CFG_STROBE_FAMILY;
	assign lnk.endian_strap = strap_reg[STRAP_ENDIAN_BIT];
	assign lnk.bus_status_n = strap_reg[STRAP_BS_BIT];
	assign lnk.rd_wr_n = 1'b1;
	assign lnk.chip_select_n = cs_reg;
	assign lnk.read_strobe_n = rd_reg;
	assign lnk.low_write_strobe_n = we0_reg;
	assign lnk.high_byte_enable_n = we1_reg;
	assign lnk.host_address_inputs = addr_reg;
	assign lnk.host_data_out = wdata_reg;
	assign lnk.host_data_oe = doe_reg;

	// Link clock divider; free running
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_reg <= 4'h0;
			hbclk_reg <= 1'b0;
		end
		else if (div_reg == 4'(HBCLK_HALF - 1))
		begin
			div_reg <= 4'h0;
			hbclk_reg <= ~hbclk_reg;
		end
		else
			div_reg <= div_reg + 4'h1;
	end

	// Wait line synchroniser; active low line used as is, no inverter needed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_s1_reg <= 1'b1;
			wait_s2_reg <= 1'b1;
		end
		else
		begin
			wait_s1_reg <= lnk.wait_n;
			wait_s2_reg <= wait_s1_reg;
		end
	end

	// APB slave: answers on the second access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
			ctrl_reg <= 18'h0;
			wdata_reg <= 16'h0;
			strap_reg <= STRAP_RESET;
		end
		else
		begin
			pready <= psel & penable & ~pready;
			pslverr <= 1'b0;
			if (psel & penable & ~pready)
			begin
				unique case (paddr)
					OFS_CTRL: prdata <= {14'h0, ctrl_reg};
					OFS_WDATA: prdata <= {16'h0, wdata_reg};
					OFS_RDATA: prdata <= {16'h0, rdata_reg};
					OFS_STATUS: prdata <= {30'h0, done_reg, ~state_reg[0]};
					OFS_STRAP: prdata <= {30'h0, strap_reg};
					default:
					begin
						prdata <= 32'h0;
						pslverr <= 1'b1; // Unmapped offset
					end
				endcase
			end
			if (go)
				ctrl_reg <= pwdata[17:0];
			if (apb_wr & (paddr == OFS_WDATA))
				wdata_reg <= pwdata[15:0];
			if (apb_wr & (paddr == OFS_STRAP))
				strap_reg <= pwdata[1:0]; // Takes effect at next device reset
		end
	end

	// Transfer sequencer: chip select asserted on every start, strobes from direction
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= H_IDLE;
			cnt_reg <= 4'h0;
			cs_reg <= 1'b1;
			rd_reg <= 1'b1;
			we0_reg <= 1'b1;
			we1_reg <= 1'b1;
			doe_reg <= 1'b0;
			addr_reg <= 16'h0;
			rdata_reg <= 16'h0;
			done_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				H_IDLE:
				begin
					if (go)
					begin
						// Only sixteen address bits leave; higher host bits alias the port
						addr_reg <= pwdata[15:0];
						cs_reg <= 1'b0;
						we1_reg <= ~pwdata[CTRL_HIGH_BIT];
						doe_reg <= pwdata[CTRL_WRITE_BIT];
						state_reg <= H_SETUP;
					end
				end
				H_SETUP:
				begin
					rd_reg <= ctrl_reg[CTRL_WRITE_BIT];
					we0_reg <= ~ctrl_reg[CTRL_WRITE_BIT];
					cnt_reg <= HOST_SETTLE;
					state_reg <= H_SETTLE;
				end
				H_SETTLE:
				begin
					cnt_reg <= cnt_reg - 4'h1;
					if (cnt_reg == 4'h1)
						state_reg <= H_WAIT;
				end
				H_WAIT:
				begin
					if (wait_s2_reg)
					begin
						rdata_reg <= lnk.host_data_lines;
						cs_reg <= 1'b1;
						rd_reg <= 1'b1;
						we0_reg <= 1'b1;
						we1_reg <= 1'b1;
						doe_reg <= 1'b0;
						cnt_reg <= HOST_RECOVER;
						state_reg <= H_RECOV;
					end
				end
				H_RECOV:
				begin
					cnt_reg <= cnt_reg - 4'h1;
					if (cnt_reg == 4'h1)
					begin
						done_reg <= 1'b1;
						state_reg <= H_IDLE;
					end
				end
			endcase
			// Completion in the same cycle as a new start still reads back as done
			if (go & ~(state_reg[4] & (cnt_reg == 4'h1)))
				done_reg <= 1'b0;
		end
	end
endmodule : lcdc_host_end

// ---- lcdc_dev_end.sv ----
// Purpose: controller end of the strobe host bus port
// Assumes: memory and registers sit behind the user-side access port
// Notes: only strobe mode B runs cycles; other strap settings leave the port idle
`timescale 1ns/1ps

// Summary of operation
// - Sample straps at reset, then hold
// - Straps 111 plus status high: mode B
// - Endian strap latched; high means big endian
// - Transfers aligned to host bus clock
// - Sixteen address and sixteen data lines
// - Host asserts chip select on every start
// - High enable both ways; low strobe writes
// - Host drives read strobe low for reads
// - Wait low until arbitration with refresh ends
// - Host inverts wait if its input active-high
// - Direction pin tied high; status pin from STRAP register
// - Display memory at 0 through 9FFFh
// - Registers at FFE0h through FFFFh
// - Host gives 64K window; higher host bits alias
// - Async select, strobe and bus clock pins synchronised inside; high enable taken unsynced with the address
// - Pixel clock async; 25 or 50 MHz max
module lcdc_dev_end
	import lcdc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link pins
	lcdc_link_if.dev lnk,
	// Access port toward memory and registers
	output logic acc_req,
	output logic acc_write,
	output logic acc_reg_sel,
	output logic [15:0] acc_addr,
	output logic [15:0] acc_wdata,
	output logic [1:0] acc_lane,
	input wire logic acc_ack,
	input wire logic [15:0] acc_rdata,
	// Refresh arbitration, from the pixel clock domain
	input wire logic refresh_busy,
	// Latched configuration
	output logic mode_valid,
	output logic mode_big_endian
);
	typedef enum logic [4:0] {
		D_IDLE = 5'b00001,
		D_ALIGN = 5'b00010,
		D_ARB = 5'b00100,
		D_ACK = 5'b01000,
		D_DONE = 5'b10000
	} lcdc_dstate_t;

	lcdc_dstate_t state_reg; // Cycle sequencer
	logic [4:0] s1_reg; // First sync stage, read only by s2_reg
	logic [4:0] s2_reg; // Second sync stage
	logic [4:0] strap_s1_reg; // Strap sync, first stage
	logic [4:0] strap_s2_reg; // Strap sync, second stage
	logic [1:0] prime_reg; // Counts sync stages filled after reset
	logic hb_last_reg; // Previous synced bus clock
	logic latched_reg; // Straps have been captured
	logic big_reg; // Endian selection
	logic valid_reg; // Strobe mode B selected
	logic wait_n_reg; // Wait pin
	logic [15:0] dout_reg; // Read data pin value
	logic doe_reg; // Read data drive enable
	logic cs_n, rd_n, we0_n, hb, busy; // Synced pins
	logic active; // A strobe cycle is under way
	logic hb_rise; // Rising edge of host bus clock
	logic gap; // Address falls between windows
	logic [15:0] wd_swap; // Host write data in controller byte order
	logic [15:0] rd_swap; // Read data in host byte order
	logic [1:0] lanes; // Lanes in controller byte order

	assign cs_n = s2_reg[0];
	assign rd_n = s2_reg[1];
	assign we0_n = s2_reg[2];
	assign hb = s2_reg[3];
	assign busy = s2_reg[4];
	assign hb_rise = hb & ~hb_last_reg;
	assign active = latched_reg & valid_reg & ~cs_n & (~rd_n | ~we0_n);

	// Between the memory and register windows nothing is decoded
	assign gap = (lnk.host_address_inputs > MEM_LAST) & (lnk.host_address_inputs < REG_FIRST);

	// Big endian swaps bytes and lanes on the way in and out
	assign wd_swap = big_reg ? {lnk.host_data_lines[7:0], lnk.host_data_lines[15:8]} : lnk.host_data_lines;
	assign rd_swap = big_reg ? {acc_rdata[7:0], acc_rdata[15:8]} : acc_rdata;
	assign lanes = big_reg ? {~lnk.host_address_inputs[0], ~lnk.high_byte_enable_n}
		: {~lnk.high_byte_enable_n, ~lnk.host_address_inputs[0]};

	// Pins and status straight from flops
	assign lnk.wait_n = wait_n_reg;
	assign lnk.dev_data_out = dout_reg;
	assign lnk.dev_data_oe = doe_reg;
	assign mode_valid = valid_reg;
	assign mode_big_endian = big_reg;

	// Two-stage synchronisers for select, strobes, bus clock and refresh busy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_reg <= 5'h07;
			s2_reg <= 5'h07;
			hb_last_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= {refresh_busy, lnk.host_bus_clock, lnk.low_write_strobe_n,
				lnk.read_strobe_n, lnk.chip_select_n};
			s2_reg <= s1_reg;
			hb_last_reg <= hb;
		end
	end

	// Strap pins pass two flops too; the count tells when the second stage holds them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strap_s1_reg <= 5'h00;
			strap_s2_reg <= 5'h00;
			prime_reg <= 2'h0;
		end
		else
		begin
			strap_s1_reg <= {lnk.bus_config_straps, lnk.endian_strap, lnk.bus_status_n};
			strap_s2_reg <= strap_s1_reg;
			if (prime_reg != 2'h2)
				prime_reg <= prime_reg + 2'h1;
		end
	end

	// Straps are caught once both sync stages hold them, then frozen
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			latched_reg <= 1'b0;
			big_reg <= 1'b0;
			valid_reg <= 1'b0;
		end
		else if (!latched_reg && (prime_reg == 2'h2))
		begin
			latched_reg <= 1'b1;
			big_reg <= strap_s2_reg[1];
			// Mode A, status strap low, is recognised but not served
			valid_reg <= (strap_s2_reg[4:2] == CFG_STROBE_FAMILY) & strap_s2_reg[0];
		end
	end

	// Cycle sequencer. Address and data are sampled only once the synced
	// strobes are seen, by which time the host holds them steady.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= D_IDLE;
			wait_n_reg <= 1'b1;
			dout_reg <= 16'h0;
			doe_reg <= 1'b0;
			acc_req <= 1'b0;
			acc_write <= 1'b0;
			acc_reg_sel <= 1'b0;
			acc_addr <= 16'h0;
			acc_wdata <= 16'h0;
			acc_lane <= 2'h0;
		end
		else
		begin
			unique case (state_reg)
				D_IDLE:
				begin
					// Hold the host at once; arbitration is still ahead
					if (active)
					begin
						wait_n_reg <= 1'b0;
						state_reg <= D_ALIGN;
					end
				end
				D_ALIGN:
				begin
					// Start the access on a host bus clock rising edge
					if (hb_rise)
					begin
						acc_addr <= lnk.host_address_inputs;
						acc_wdata <= wd_swap;
						acc_lane <= lanes;
						acc_write <= ~we0_n;
						acc_reg_sel <= lnk.host_address_inputs >= REG_FIRST;
						if (gap)
						begin
							// Complete without touching storage
							dout_reg <= GAP_READ_VALUE;
							doe_reg <= ~rd_n;
							wait_n_reg <= 1'b1;
							state_reg <= D_DONE;
						end
						else
							state_reg <= D_ARB;
					end
				end
				D_ARB:
				begin
					// Refresh owns the store while busy is seen
					if (!busy)
					begin
						acc_req <= 1'b1;
						state_reg <= D_ACK;
					end
				end
				D_ACK:
				begin
					acc_req <= 1'b0;
					if (acc_ack)
					begin
						dout_reg <= rd_swap;
						doe_reg <= ~acc_write;
						wait_n_reg <= 1'b1;
						state_reg <= D_DONE;
					end
				end
				D_DONE:
				begin
					// Keep read data on the bus until the host lets go
					if (cs_n | (rd_n & we0_n))
					begin
						doe_reg <= 1'b0;
						state_reg <= D_IDLE;
					end
				end
			endcase
		end
	end
endmodule : lcdc_dev_end

// ---- lcdc_link_monitor.sv ----
// Purpose: checker on the link pins between host glue and controller port
// Assumes: both link ends are design modules sharing pclk; the controller end can also be reset alone
// Notes: host bus clock half period of 7 pclk cycles is the host end's divider
`timescale 1ns/1ps
module lcdc_link_monitor
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link pins
	input wire logic host_bus_clock,
	input wire logic [2:0] bus_config_straps,
	input wire logic rd_wr_n,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic low_write_strobe_n,
	input wire logic high_byte_enable_n,
	input wire logic [15:0] host_address_inputs,
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	input wire logic wait_n
);
	// One domain, so one clocking and one disable for all checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_straps;
		bus_config_straps == 3'h7 && rd_wr_n;
	endproperty
	a_straps: assert property (p_straps) else $error("strap pins moved");
	property p_host_bus_clock;
		$rose(host_bus_clock) |-> host_bus_clock [*7] ##1 !host_bus_clock;
	endproperty
	a_host_bus_clock: assert property (p_host_bus_clock) else $error("bus clock high phase wrong");
	property p_wait_cs;
		!wait_n |-> !chip_select_n;
	endproperty
	a_wait_cs: assert property (p_wait_cs) else $error("wait held without select");
	property p_rd_ready;
		$rose(wait_n) && !read_strobe_n |-> dev_data_oe;
	endproperty
	a_rd_ready: assert property (p_rd_ready) else $error("read ended without data");
	property p_no_fight;
		!(dev_data_oe && host_data_oe);
	endproperty
	a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
	property p_wr_quiet;
		!low_write_strobe_n |-> !dev_data_oe;
	endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("device drove during write");
	property p_one_strobe;
		!(!read_strobe_n && !low_write_strobe_n);
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("read and write strobes together");
	property p_strobe_cs;
		(!read_strobe_n || !low_write_strobe_n) |-> !chip_select_n;
	endproperty
	a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select");
	property p_hold;
		!wait_n |-> $stable(host_address_inputs) && $stable(high_byte_enable_n);
	endproperty
	a_hold: assert property (p_hold) else $error("address moved while held");
endmodule : lcdc_link_monitor

// ---- lcdc_strobe_host_bus_port_tb_top.sv ----
// Purpose: bench driving the host end over APB through the link to the controller end
// Assumes: access port answered by a small memory stand-in one cycle after each request
// Notes: the controller end has its own reset so strap changes can be relatched
`timescale 1ns/1ps
module lcdc_strobe_host_bus_port_tb_top
	import lcdc_pkg::*;
;
	logic pclk = 1'b0; // Bench clock
	logic presetn, dev_hold_n, psel, penable, pwrite, refresh_busy, acc_ack, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, acc_req, acc_write, acc_reg_sel, mode_valid, mode_big_endian;
	logic [15:0] acc_addr, acc_wdata, acc_rdata;
	logic [1:0] acc_lane;
	logic [35:0] cap; // Last access request seen
	int acc_cnt = 0, cyc = 0, error_cnt = 0, checks_done = 0;
	wire logic dev_rstn = presetn & dev_hold_n; // Controller-only reset
	lcdc_link_if lnk ();
	lcdc_host_end u_lcdc_host_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lnk(lnk));
	lcdc_dev_end u_lcdc_dev_end (.pclk(pclk), .presetn(dev_rstn), .lnk(lnk), .acc_req(acc_req),
		.acc_write(acc_write), .acc_reg_sel(acc_reg_sel), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
		.acc_lane(acc_lane), .acc_ack(acc_ack), .acc_rdata(acc_rdata), .refresh_busy(refresh_busy),
		.mode_valid(mode_valid), .mode_big_endian(mode_big_endian));
	lcdc_link_monitor u_lcdc_link_monitor (.pclk(pclk), .presetn(presetn),
		.host_bus_clock(lnk.host_bus_clock), .bus_config_straps(lnk.bus_config_straps),
		.rd_wr_n(lnk.rd_wr_n), .chip_select_n(lnk.chip_select_n), .read_strobe_n(lnk.read_strobe_n),
		.low_write_strobe_n(lnk.low_write_strobe_n), .high_byte_enable_n(lnk.high_byte_enable_n),
		.host_address_inputs(lnk.host_address_inputs), .host_data_oe(lnk.host_data_oe),
		.dev_data_oe(lnk.dev_data_oe), .wait_n(lnk.wait_n));
	// Memory stand-in content, a scramble of the address
	function automatic logic [15:0] mdl(input logic [15:0] a);
		return {a[7:0], a[15:8]} ^ 16'h3c5a;
	endfunction : mdl
	initial
	begin
		forever #(PCLK_PERIOD_NS / 2) pclk = ~pclk;
	end
	// Access port answer and capture; timeout guard
	always @(posedge pclk)
	begin
		acc_ack <= acc_req;
		acc_rdata <= mdl(acc_addr);
		cyc <= cyc + 1;
		if (acc_req === 1'b1)
		begin
			acc_cnt <= acc_cnt + 1;
			cap <= {acc_write, acc_reg_sel, acc_lane, acc_addr, acc_wdata};
		end
		if (cyc == 40000)
		begin
			error_cnt++;
			$display("mismatch at %0t: timeout", $time);
			end_sim();
		end
	end
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task chk(input logic [35:0] seen, input logic [35:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer; held until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wait_done;
		rd = 32'h0;
		while (rd[1] !== 1'b1)
			apb(1'b0, OFS_STATUS, 32'h0);
	endtask : wait_done
	task dev_reset;
		@(posedge pclk);
		dev_hold_n <= 1'b0;
		repeat (3) @(posedge pclk);
		dev_hold_n <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask : dev_reset
	// One strobe cycle through both ends, judged at the access port and in RDATA
	task xfer(input logic wr, input logic hi, input logic [15:0] a, input logic [15:0] d, input logic big);
		int n0;
		logic gap;
		logic [35:0] msk;
		logic [15:0] m;
		n0 = acc_cnt;
		m = mdl(a);
		gap = (a > MEM_LAST) && (a < REG_FIRST);
		msk = wr ? 36'hfffffffff : 36'hfffff0000;
		apb(1'b1, OFS_WDATA, {16'h0, d});
		apb(1'b1, OFS_CTRL, {14'h0, hi, wr, a});
		wait_done();
		chk(36'(acc_cnt - n0), 36'(!gap));
		if (!gap)
			chk(cap & msk, {wr, a >= REG_FIRST, big ? {~a[0], hi} : {hi, ~a[0]}, a, big ? {d[7:0], d[15:8]} : d} & msk);
		if (!wr)
		begin
			apb(1'b0, OFS_RDATA, 32'h0);
			chk(36'(rd[15:0]), 36'(gap ? GAP_READ_VALUE : (big ? {m[7:0], m[15:8]} : m)));
		end
	endtask : xfer
	task t_straps;
		chk(36'({mode_valid, mode_big_endian}), 36'h2);
		apb(1'b0, OFS_STRAP, 32'h0);
		chk(36'(rd[1:0]), 36'(STRAP_RESET));
		apb(1'b0, 8'h14, 32'h0);
		chk({3'h0, er, rd}, 36'h100000000);
		$display("test straps done");
	endtask : t_straps
	task t_windows;
		xfer(1'b1, 1'b1, MEM_FIRST, 16'h1234, 1'b0);
		xfer(1'b1, 1'b1, MEM_LAST, 16'hbeef, 1'b0);
		xfer(1'b0, 1'b0, 16'h9ffe, 16'h0, 1'b0);
		xfer(1'b1, 1'b0, REG_FIRST, 16'h00a5, 1'b0);
		xfer(1'b0, 1'b1, 16'hffff, 16'h0, 1'b0);
		xfer(1'b0, 1'b1, 16'ha000, 16'h0, 1'b0);
		xfer(1'b1, 1'b1, 16'hffdf, 16'h5555, 1'b0);
		$display("test windows done");
	endtask : t_windows
	// Refresh holds the host cycle off until it drops
	task t_refresh;
		int n0;
		n0 = acc_cnt;
		refresh_busy <= 1'b1;
		apb(1'b1, OFS_CTRL, {14'h0, 2'b10, 16'h0040});
		repeat (60) @(posedge pclk);
		chk(36'(acc_cnt - n0), 36'h0);
		chk(36'(lnk.wait_n), 36'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(36'(rd[1:0]), 36'h1);
		refresh_busy <= 1'b0;
		wait_done();
		apb(1'b0, OFS_RDATA, 32'h0);
		chk(36'(rd[15:0]), 36'(mdl(16'h0040)));
		$display("test refresh done");
	endtask : t_refresh
	// Straps only count at the next controller reset
	task t_modes;
		apb(1'b1, OFS_STRAP, 32'h3);
		repeat (4) @(posedge pclk);
		chk(36'({mode_valid, mode_big_endian}), 36'h2);
		dev_reset();
		chk(36'({mode_valid, mode_big_endian}), 36'h3);
		xfer(1'b1, 1'b0, 16'h0002, 16'h1234, 1'b1);
		xfer(1'b0, 1'b1, 16'h0100, 16'h0, 1'b1);
		apb(1'b1, OFS_STRAP, 32'h0);
		dev_reset();
		chk(36'({mode_valid, mode_big_endian}), 36'h0);
		apb(1'b1, OFS_STRAP, 32'h2);
		dev_reset();
		chk(36'({mode_valid, mode_big_endian}), 36'h2);
		$display("test modes done");
	endtask : t_modes
	initial
	begin
		presetn = 1'b0;
		dev_hold_n = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		refresh_busy = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_straps();
		t_windows();
		t_refresh();
		t_modes();
		end_sim();
	end
endmodule : lcdc_strobe_host_bus_port_tb_top
